/* rtl/quick_stop_sequencer.sv */
// quick stop sequencer with axi4-lite registers and interrupt
`timescale 1ns/1ps
module quick_stop_sequencer (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // controller commands
  input wire logic I_QUICK_STOP,
  input wire logic I_ENABLE_OP,
  input wire logic I_DISABLE_VOLTAGE,
  input wire logic I_CMD_STOP,
  input wire logic [3:0] I_OP_MODE,
  // drive side
  input wire logic I_FORCED_STOP_INPUT_TWO,
  input wire logic I_ALARM_FSD,
  input wire logic I_WARN_FSD,
  input wire logic I_WARN_QS,
  input wire logic I_MASTER_STOP,
  input wire logic I_MOTOR_STOPPED,
  // stop outputs
  output logic [1:0] O_PDS_STATE,
  output logic O_SERVO_ON,
  output logic O_DYN_BRAKE,
  output logic O_DECEL_ACTIVE,
  output logic [2:0] O_DECEL_SRC,
  output logic [31:0] O_DECEL_RATE,
  output logic [15:0] O_FSD_TIME_MS,
  output logic [31:0] O_FSD_RATE,
  output logic O_IRQ,
  // axi4-lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    qs_pkg::seq_state_t st;
    logic keep_on;
    logic [2:0] src;
    logic [1:0] pds;
    logic servo_on;
    logic dyn_brake;
    logic decel;
    logic [31:0] decel_rate;
    logic qs_prev;
    logic em2_s1;
    logic em2_s2;
    logic fsd_en;
    logic [2:0] method;
    logic [15:0] fsd_time;
    logic [31:0] fsd_rate;
    logic [31:0] qs_decel;
    logic [qs_pkg::IRQ_W-1:0] irq_sts;
    logic [qs_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_regs_t;

  seq_regs_t q_ff;
  seq_regs_t nxt_q;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic qs_fall;
  logic em2_low;
  logic mode_ok;
  logic is_torque;
  logic is_slt;
  assign qs_fall = q_ff.qs_prev & ~I_QUICK_STOP;
  // the first synchroniser stage is never looked at here
  assign em2_low = ~q_ff.em2_s2;
  assign mode_ok = (I_OP_MODE == qs_pkg::MODE_CSP) || (I_OP_MODE == qs_pkg::MODE_CSV) ||
                   (I_OP_MODE == qs_pkg::MODE_CST) || (I_OP_MODE == qs_pkg::MODE_PP) ||
                   (I_OP_MODE == qs_pkg::MODE_PV) || (I_OP_MODE == qs_pkg::MODE_TQ) ||
                   (I_OP_MODE == qs_pkg::MODE_PT) || (I_OP_MODE == qs_pkg::MODE_JG) ||
                   (I_OP_MODE == qs_pkg::MODE_HM);
  assign is_torque = (I_OP_MODE == qs_pkg::MODE_TQ) || (I_OP_MODE == qs_pkg::MODE_CST) ||
                     (I_OP_MODE == qs_pkg::MODE_CT);
  assign is_slt = (I_OP_MODE == qs_pkg::MODE_SLT);

  always_comb begin
    logic [qs_pkg::IRQ_W-1:0] ev;
    logic [qs_pkg::IRQ_W-1:0] clr;
    logic [31:0] wv;
    logic [31:0] rv;
    logic hit;
    ev = '0;
    clr = '0;
    wv = '0;
    rv = '0;
    hit = 1'b0;
    nxt_q = q_ff;
    nxt_q.qs_prev = I_QUICK_STOP;
    nxt_q.em2_s1 = I_FORCED_STOP_INPUT_TWO;
    nxt_q.em2_s2 = q_ff.em2_s1;

    case (q_ff.st)
      qs_pkg::ST_SOD: begin
        if (I_ENABLE_OP && I_QUICK_STOP && !em2_low) begin
          nxt_q.st = qs_pkg::ST_OPEN;
        end else if (qs_fall) begin
          ev[qs_pkg::IRQ_IGNORED] = 1'b1;
        end
      end
      qs_pkg::ST_OPEN: begin
        if (is_slt) begin
          // slave axis follows the master, the quick stop bit has no say
          if (I_MASTER_STOP) begin
            nxt_q.st = qs_pkg::ST_DECEL;
            nxt_q.src = qs_pkg::SRC_MASTER;
            nxt_q.keep_on = 1'b0;
          end else if (qs_fall) begin
            ev[qs_pkg::IRQ_IGNORED] = 1'b1;
          end
        end else if (qs_fall || em2_low) begin
          ev[qs_pkg::IRQ_ACCEPT] = 1'b1;
          nxt_q.keep_on = 1'b0;
          nxt_q.src = qs_pkg::SRC_NONE;
          nxt_q.st = qs_pkg::ST_DB;
          if (!q_ff.fsd_en) begin
            nxt_q.st = qs_pkg::ST_DB;
          end else if (em2_low) begin
            nxt_q.st = qs_pkg::ST_DECEL;
            nxt_q.src = qs_pkg::SRC_QSD;
          end else if (I_CMD_STOP) begin
            nxt_q.st = qs_pkg::ST_DB;
          end else if (is_torque || !mode_ok) begin
            nxt_q.st = qs_pkg::ST_DB;
          end else begin
            case (q_ff.method)
              qs_pkg::METH_MODE_OFF: begin
                nxt_q.st = qs_pkg::ST_DECEL;
                nxt_q.src = qs_pkg::SRC_MODE;
              end
              qs_pkg::METH_QSD_OFF: begin
                nxt_q.st = qs_pkg::ST_DECEL;
                nxt_q.src = qs_pkg::SRC_QSD;
              end
              qs_pkg::METH_MODE_HOLD: begin
                nxt_q.st = qs_pkg::ST_DECEL;
                nxt_q.src = qs_pkg::SRC_MODE;
                nxt_q.keep_on = 1'b1;
              end
              qs_pkg::METH_QSD_HOLD: begin
                nxt_q.st = qs_pkg::ST_DECEL;
                nxt_q.src = qs_pkg::SRC_QSD;
                nxt_q.keep_on = 1'b1;
              end
              default: begin
                nxt_q.st = qs_pkg::ST_DB;
              end
            endcase
          end
        end else if (I_DISABLE_VOLTAGE) begin
          nxt_q.st = qs_pkg::ST_SOD;
        end
      end
      qs_pkg::ST_DECEL: begin
        if (I_MOTOR_STOPPED) begin
          nxt_q.st = q_ff.keep_on ? qs_pkg::ST_HOLD : qs_pkg::ST_SOD;
          ev[qs_pkg::IRQ_STOPPED] = 1'b1;
        end else if (I_ALARM_FSD) begin
          nxt_q.st = qs_pkg::ST_FAULT;
          nxt_q.src = qs_pkg::SRC_QSD;
          nxt_q.keep_on = 1'b0;
          ev[qs_pkg::IRQ_FAULT] = 1'b1;
        end else if (I_WARN_QS) begin
          nxt_q.src = qs_pkg::SRC_WARN;
          nxt_q.keep_on = 1'b0;
        end else if (I_WARN_FSD || em2_low) begin
          nxt_q.src = qs_pkg::SRC_QSD;
          nxt_q.keep_on = 1'b0;
        end
      end
      qs_pkg::ST_FAULT, qs_pkg::ST_DB: begin
        if (I_MOTOR_STOPPED) begin
          nxt_q.st = qs_pkg::ST_SOD;
          ev[qs_pkg::IRQ_STOPPED] = 1'b1;
        end
      end
      qs_pkg::ST_HOLD: begin
        if (em2_low || I_DISABLE_VOLTAGE) begin
          nxt_q.st = qs_pkg::ST_SOD;
        end else if (I_ENABLE_OP && I_QUICK_STOP) begin
          nxt_q.st = qs_pkg::ST_OPEN;
        end
      end
      default: begin
        nxt_q.st = qs_pkg::ST_SOD;
      end
    endcase

    if (nxt_q.st == qs_pkg::ST_SOD || nxt_q.st == qs_pkg::ST_OPEN || nxt_q.st == qs_pkg::ST_DB) begin
      nxt_q.src = qs_pkg::SRC_NONE;
      nxt_q.keep_on = 1'b0;
    end
    nxt_q.servo_on = (nxt_q.st != qs_pkg::ST_SOD) && (nxt_q.st != qs_pkg::ST_DB);
    nxt_q.dyn_brake = (nxt_q.st == qs_pkg::ST_DB);
    nxt_q.decel = (nxt_q.st == qs_pkg::ST_DECEL) || (nxt_q.st == qs_pkg::ST_FAULT);
    // a held stop outputs zero speed demand; the drive loop holds position
    nxt_q.decel_rate = (nxt_q.decel && nxt_q.src == qs_pkg::SRC_QSD) ? q_ff.qs_decel : '0;
    case (nxt_q.st)
      qs_pkg::ST_OPEN: nxt_q.pds = qs_pkg::PDS_OPEN;
      qs_pkg::ST_DECEL: nxt_q.pds = (nxt_q.src == qs_pkg::SRC_MASTER) ? qs_pkg::PDS_OPEN : qs_pkg::PDS_QSA;
      qs_pkg::ST_HOLD, qs_pkg::ST_DB: nxt_q.pds = qs_pkg::PDS_QSA;
      qs_pkg::ST_FAULT: nxt_q.pds = qs_pkg::PDS_FRA;
      default: nxt_q.pds = qs_pkg::PDS_SOD;
    endcase

    // write channel: address and data may arrive in either order
    if (S_AXI_AWVALID && q_ff.awready) begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q_ff.wready) begin
      nxt_q.w_got = 1'b1;
      nxt_q.wdata = S_AXI_WDATA;
      nxt_q.wstrb = S_AXI_WSTRB;
    end
    if (q_ff.aw_got && q_ff.w_got && !q_ff.bvalid) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got = 1'b0;
      nxt_q.bvalid = 1'b1;
      hit = 1'b1;
      case (q_ff.awaddr)
        qs_pkg::OFS_CTRL: begin
          wv = merge_bytes({31'h0, q_ff.fsd_en}, q_ff.wdata, q_ff.wstrb);
          nxt_q.fsd_en = wv[qs_pkg::CTRL_FSD_EN_BIT];
        end
        qs_pkg::OFS_QS_METHOD, qs_pkg::OFS_QS_OPTION: begin
          // unsupported codes are dropped so the stored method stays valid
          wv = merge_bytes({29'h0, q_ff.method}, q_ff.wdata, q_ff.wstrb);
          if (wv[31:3] == '0 && (wv[2:0] == qs_pkg::METH_DB || wv[2:0] == qs_pkg::METH_MODE_OFF ||
              wv[2:0] == qs_pkg::METH_QSD_OFF || wv[2:0] == qs_pkg::METH_MODE_HOLD ||
              wv[2:0] == qs_pkg::METH_QSD_HOLD)) begin
            nxt_q.method = wv[2:0];
          end
        end
        qs_pkg::OFS_FSD_TIME: begin
          wv = merge_bytes({16'h0, q_ff.fsd_time}, q_ff.wdata, q_ff.wstrb);
          nxt_q.fsd_time = wv[15:0];
        end
        qs_pkg::OFS_FSD_RATE: nxt_q.fsd_rate = merge_bytes(q_ff.fsd_rate, q_ff.wdata, q_ff.wstrb);
        qs_pkg::OFS_QS_DECEL: nxt_q.qs_decel = merge_bytes(q_ff.qs_decel, q_ff.wdata, q_ff.wstrb);
        qs_pkg::OFS_STATUS: begin
        end
        qs_pkg::OFS_IRQ_STS: begin
          if (q_ff.wstrb[0]) begin
            clr = q_ff.wdata[qs_pkg::IRQ_W-1:0];
          end
        end
        qs_pkg::OFS_IRQ_MASK: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.irq_mask = q_ff.wdata[qs_pkg::IRQ_W-1:0];
          end
        end
        default: hit = 1'b0;
      endcase
      nxt_q.bresp = hit ? qs_pkg::RESP_OKAY : qs_pkg::RESP_SLVERR;
    end else if (q_ff.bvalid && S_AXI_BREADY) begin
      nxt_q.bvalid = 1'b0;
    end
    nxt_q.awready = !nxt_q.aw_got && !nxt_q.bvalid;
    nxt_q.wready = !nxt_q.w_got && !nxt_q.bvalid;

    // new events win over a clear in the same cycle
    nxt_q.irq_sts = (q_ff.irq_sts & ~clr) | ev;
    nxt_q.irq = |(nxt_q.irq_sts & nxt_q.irq_mask);

    if (S_AXI_ARVALID && q_ff.arready) begin
      hit = 1'b1;
      case (S_AXI_ARADDR)
        qs_pkg::OFS_CTRL: rv[qs_pkg::CTRL_FSD_EN_BIT] = q_ff.fsd_en;
        qs_pkg::OFS_QS_METHOD, qs_pkg::OFS_QS_OPTION: rv[2:0] = q_ff.method;
        qs_pkg::OFS_FSD_TIME: rv[15:0] = q_ff.fsd_time;
        qs_pkg::OFS_FSD_RATE: rv = q_ff.fsd_rate;
        qs_pkg::OFS_QS_DECEL: rv = q_ff.qs_decel;
        qs_pkg::OFS_STATUS: begin
          rv[qs_pkg::STS_PDS_LSB +: 2] = q_ff.pds;
          rv[qs_pkg::STS_SERVO_BIT] = q_ff.servo_on;
          rv[qs_pkg::STS_DB_BIT] = q_ff.dyn_brake;
          rv[qs_pkg::STS_DECEL_BIT] = q_ff.decel;
          rv[qs_pkg::STS_KEEP_BIT] = q_ff.keep_on;
          rv[qs_pkg::STS_SRC_LSB +: 3] = q_ff.src;
          rv[qs_pkg::STS_EM2_BIT] = em2_low;
        end
        qs_pkg::OFS_IRQ_STS: rv[qs_pkg::IRQ_W-1:0] = q_ff.irq_sts;
        qs_pkg::OFS_IRQ_MASK: rv[qs_pkg::IRQ_W-1:0] = q_ff.irq_mask;
        default: hit = 1'b0;
      endcase
      nxt_q.rvalid = 1'b1;
      nxt_q.arready = 1'b0;
      nxt_q.rdata = rv;
      nxt_q.rresp = hit ? qs_pkg::RESP_OKAY : qs_pkg::RESP_SLVERR;
    end else if (q_ff.rvalid && S_AXI_RREADY) begin
      nxt_q.rvalid = 1'b0;
      nxt_q.arready = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q_ff <= '0;
      q_ff.st <= qs_pkg::ST_SOD;
      q_ff.qs_prev <= 1'b1;
      q_ff.em2_s1 <= 1'b1;
      q_ff.em2_s2 <= 1'b1;
      q_ff.fsd_en <= qs_pkg::RST_FSD_EN;
      q_ff.method <= qs_pkg::RST_METHOD;
      q_ff.fsd_time <= qs_pkg::RST_FSD_TIME_MS;
      q_ff.fsd_rate <= qs_pkg::RST_FSD_RATE;
      q_ff.qs_decel <= qs_pkg::RST_QS_DECEL;
      q_ff.awready <= 1'b1;
      q_ff.wready <= 1'b1;
      q_ff.arready <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign O_PDS_STATE = q_ff.pds;
  assign O_SERVO_ON = q_ff.servo_on;
  assign O_DYN_BRAKE = q_ff.dyn_brake;
  assign O_DECEL_ACTIVE = q_ff.decel;
  assign O_DECEL_SRC = q_ff.src;
  assign O_DECEL_RATE = q_ff.decel_rate;
  assign O_FSD_TIME_MS = q_ff.fsd_time;
  assign O_FSD_RATE = q_ff.fsd_rate;
  assign O_IRQ = q_ff.irq;
  assign S_AXI_AWREADY = q_ff.awready;
  assign S_AXI_WREADY = q_ff.wready;
  assign S_AXI_BVALID = q_ff.bvalid;
  assign S_AXI_BRESP = q_ff.bresp;
  assign S_AXI_ARREADY = q_ff.arready;
  assign S_AXI_RVALID = q_ff.rvalid;
  assign S_AXI_RDATA = q_ff.rdata;
  assign S_AXI_RRESP = q_ff.rresp;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  chk_decel_from_open: assert property (
    (q_ff.st == qs_pkg::ST_DECEL) && ($past(q_ff.st) != qs_pkg::ST_DECEL) |-> $past(q_ff.st) == qs_pkg::ST_OPEN)
    else $error("decel entered from a state other than operation enabled");
  chk_db_when_disabled: assert property (
    (q_ff.st == qs_pkg::ST_OPEN) && !is_slt && qs_fall && !q_ff.fsd_en |=> O_DYN_BRAKE && !O_SERVO_ON)
    else $error("disabled forced stop decel did not brake");
  chk_torque_db: assert property (
    (q_ff.st == qs_pkg::ST_OPEN) && qs_fall && is_torque && !em2_low |=> q_ff.st == qs_pkg::ST_DB)
    else $error("torque mode quick stop did not use dynamic brake");
  chk_alarm_fault: assert property (
    (q_ff.st == qs_pkg::ST_DECEL) && I_ALARM_FSD && !I_MOTOR_STOPPED
    |=> (O_PDS_STATE == qs_pkg::PDS_FRA) && (O_DECEL_SRC == qs_pkg::SRC_QSD) && O_SERVO_ON)
    else $error("alarm during decel did not enter fault reaction");
  chk_warn_keep_qsa: assert property (
    (q_ff.st == qs_pkg::ST_DECEL) && I_WARN_FSD && !I_WARN_QS && !I_ALARM_FSD && !I_MOTOR_STOPPED
    && (q_ff.src != qs_pkg::SRC_MASTER) |=> (O_PDS_STATE == qs_pkg::PDS_QSA) && !q_ff.keep_on)
    else $error("forced stop warning left quick stop active or kept servo");
  chk_warn_time: assert property (
    (q_ff.st == qs_pkg::ST_DECEL) && I_WARN_QS && !I_ALARM_FSD && !I_MOTOR_STOPPED
    |=> (O_DECEL_SRC == qs_pkg::SRC_WARN) ##1 (!q_ff.keep_on || !O_DECEL_ACTIVE))
    else $error("quick stop warning did not switch deceleration source");
  chk_cmd_stop_db: assert property (
    (q_ff.st == qs_pkg::ST_OPEN) && !is_slt && qs_fall && I_CMD_STOP && !em2_low
    |=> O_DYN_BRAKE && !O_DECEL_ACTIVE)
    else $error("command stop did not take precedence");
  chk_hold_end: assert property (
    (q_ff.st == qs_pkg::ST_DECEL) && q_ff.keep_on && I_MOTOR_STOPPED |=> O_SERVO_ON && !O_DECEL_ACTIVE
    && (O_PDS_STATE == qs_pkg::PDS_QSA))
    else $error("servo-held stop did not end in held quick stop");
  chk_em2_method2: assert property (
    (q_ff.st == qs_pkg::ST_OPEN) && !is_slt && em2_low && q_ff.fsd_en
    |=> O_DECEL_ACTIVE && (O_DECEL_SRC == qs_pkg::SRC_QSD) && !q_ff.keep_on)
    else $error("forced stop input two did not act as method 2");
  chk_slave_ignore: assert property (
    (q_ff.st == qs_pkg::ST_OPEN) && is_slt && qs_fall && !I_MASTER_STOP |=> q_ff.st == qs_pkg::ST_OPEN)
    else $error("slave torque mode reacted to quick stop");
  chk_hold_stays: assert property (
    (q_ff.st == qs_pkg::ST_HOLD) && !I_ENABLE_OP && !I_DISABLE_VOLTAGE && !em2_low
    |=> (q_ff.st == qs_pkg::ST_HOLD) && !O_DECEL_ACTIVE)
    else $error("held quick stop left without a transition command");
endmodule

/* rtl/qs_pkg.sv */
// constants, encodings and types shared by the quick stop sequencer
package qs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_QS_METHOD = 8'h04;
  localparam logic [7:0] OFS_QS_OPTION = 8'h08;
  localparam logic [7:0] OFS_FSD_TIME = 8'h0c;
  localparam logic [7:0] OFS_FSD_RATE = 8'h10;
  localparam logic [7:0] OFS_QS_DECEL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // field positions
  localparam int CTRL_FSD_EN_BIT = 0;
  localparam int STS_PDS_LSB = 0;
  localparam int STS_SERVO_BIT = 2;
  localparam int STS_DB_BIT = 3;
  localparam int STS_DECEL_BIT = 4;
  localparam int STS_KEEP_BIT = 5;
  localparam int STS_SRC_LSB = 8;
  localparam int STS_EM2_BIT = 12;
  localparam int IRQ_W = 4;
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_STOPPED = 3;
  // reset values
  localparam logic RST_FSD_EN = 1'b1;
  localparam logic [2:0] RST_METHOD = 3'h2;
  localparam logic [15:0] RST_FSD_TIME_MS = 16'h0064;
  localparam logic [31:0] RST_FSD_RATE = 32'h0000_0000;
  localparam logic [31:0] RST_QS_DECEL = 32'h0000_0000;
  // quick stop method codes
  localparam logic [2:0] METH_DB = 3'h0;
  localparam logic [2:0] METH_MODE_OFF = 3'h1;
  localparam logic [2:0] METH_QSD_OFF = 3'h2;
  localparam logic [2:0] METH_MODE_HOLD = 3'h5;
  localparam logic [2:0] METH_QSD_HOLD = 3'h6;
  // operation mode codes
  localparam logic [3:0] MODE_PP = 4'h1;
  localparam logic [3:0] MODE_PV = 4'h3;
  localparam logic [3:0] MODE_TQ = 4'h4;
  localparam logic [3:0] MODE_HM = 4'h6;
  localparam logic [3:0] MODE_CSP = 4'h8;
  localparam logic [3:0] MODE_CSV = 4'h9;
  localparam logic [3:0] MODE_CST = 4'ha;
  localparam logic [3:0] MODE_PT = 4'hc;
  localparam logic [3:0] MODE_JG = 4'hd;
  localparam logic [3:0] MODE_CT = 4'he;
  localparam logic [3:0] MODE_SLT = 4'hf;
  // drive state codes shown to the controller
  localparam logic [1:0] PDS_SOD = 2'h0;
  localparam logic [1:0] PDS_OPEN = 2'h1;
  localparam logic [1:0] PDS_QSA = 2'h2;
  localparam logic [1:0] PDS_FRA = 2'h3;
  // deceleration source codes and axi response codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_MODE = 3'h1;
  localparam logic [2:0] SRC_QSD = 3'h2;
  localparam logic [2:0] SRC_WARN = 3'h3;
  localparam logic [2:0] SRC_MASTER = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_SOD = 3'h0,
    ST_OPEN = 3'h1,
    ST_DECEL = 3'h2,
    ST_FAULT = 3'h3,
    ST_HOLD = 3'h4,
    ST_DB = 3'h5
  } seq_state_t;
endpackage

/* bench/qs_ctrl_model.sv */
// motion controller and motor model facing the quick stop sequencer
`timescale 1ns/1ps
module qs_ctrl_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // drive feedback
  input wire logic i_decel,
  input wire logic i_brake,
  // controlword bits and motor standstill
  output logic o_quick_stop,
  output logic o_enable_op,
  output logic o_disable_voltage,
  output logic o_motor_stopped
);
  logic [3:0] run_ff;
  initial begin
    o_quick_stop = 1'b1;
    o_enable_op = 1'b0;
    o_disable_voltage = 1'b0;
  end
  // the motor coasts eight cycles, so standstill never lands on the edge that starts a stop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) run_ff <= 4'h0;
    else if (!(i_decel | i_brake)) run_ff <= 4'h0;
    else if (run_ff != 4'h8) run_ff <= run_ff + 4'h1;
  end
  assign o_motor_stopped = (run_ff == 4'h8);
  // one controlword update, made just after a rising edge
  task automatic cmd(input logic qs, input logic en, input logic dis);
    @(posedge i_clk);
    o_quick_stop <= qs;
    o_enable_op <= en;
    o_disable_voltage <= dis;
  endtask
endmodule

/* bench/tb_quick_stop_sequencer.sv */
// self-checking bench for the quick stop sequencer
`timescale 1ns/1ps
module tb_quick_stop_sequencer;
  logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, em2 = 1'b1, alm = 1'b0, wq = 1'b0, wf = 1'b0, ms = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rate, frate, rd;
  logic [3:0] mode = qs_pkg::MODE_CSP;
  logic qs, en, dis, stp, srv, db, dec, irq, awr, wrd, bv, arr, rv;
  logic [1:0] pds, bresp, rresp, rs, bs;
  logic [2:0] src;
  logic [15:0] ftime;
  int miscompares = 0, num_checks = 0, cyc = 0;
  quick_stop_sequencer u_quick_stop_sequencer (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_QUICK_STOP(qs), .I_ENABLE_OP(en), .I_DISABLE_VOLTAGE(dis),
    .I_CMD_STOP(cs), .I_OP_MODE(mode), .I_FORCED_STOP_INPUT_TWO(em2), .I_ALARM_FSD(alm),
    .I_WARN_FSD(wf), .I_WARN_QS(wq), .I_MASTER_STOP(ms), .I_MOTOR_STOPPED(stp),
    .O_PDS_STATE(pds), .O_SERVO_ON(srv), .O_DYN_BRAKE(db), .O_DECEL_ACTIVE(dec), .O_DECEL_SRC(src),
    .O_DECEL_RATE(rate), .O_FSD_TIME_MS(ftime), .O_FSD_RATE(frate), .O_IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
  qs_ctrl_model u_qs_ctrl_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_decel(dec), .i_brake(db),
    .o_quick_stop(qs), .o_enable_op(en), .o_disable_voltage(dis), .o_motor_stopped(stp));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // aw and w are released one by one as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa = 1'b1, pw = 1'b1;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (pa | pw) begin
      @(posedge clk);
      if (awr) pa = 1'b0;
      if (wrd) pw = 1'b0;
      awv <= pa;
      wv <= pw;
    end
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    bs = bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
    rd = rdat;
    rs = rresp;
  endtask
  task automatic go_open();
    u_qs_ctrl_model.cmd(1'b1, 1'b1, 1'b0);
    u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b0);
    tick(2);
    ck("open", 32'h1, 32'(pds));
  endtask
  task automatic leave();
    u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b1);
    u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b0);
    tick(2);
    ck("off", 32'h0, 32'(pds));
  endtask
  task automatic t_reset();
    rdr(qs_pkg::OFS_FSD_TIME);
    ck("fsd time", 32'h64, rd);
    ck("fsd time out", 32'h64, 32'(ftime));
    ck("fsd rate", 32'h0, frate);
    rdr(qs_pkg::OFS_QS_OPTION);
    ck("option", 32'h2, rd);
    rdr(8'hfc);
    ck("unmapped", 32'h2, 32'(rs));
    wr(8'hfc, 32'h0);
    ck("unmapped wr", 32'h2, 32'(bs));
  endtask
  task automatic t_irq();
    u_qs_ctrl_model.cmd(1'b0, 1'b0, 1'b0);
    tick(3);
    ck("ignored", 32'h0, 32'(pds));
    ck("irq masked", 32'h0, 32'(irq));
    wr(qs_pkg::OFS_IRQ_MASK, 32'h2);
    ck("bresp", 32'h0, 32'(bs));
    tick(1);
    ck("irq", 32'h1, 32'(irq));
    wr(qs_pkg::OFS_IRQ_STS, 32'hf);
    tick(1);
    ck("irq clear", 32'h0, 32'(irq));
    u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_methods();
    logic [2:0] m [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [2:0] s [5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h2};
    // held stops run in profile position, so no csp cancel ever owes a position follow-up
    @(posedge clk);
    mode <= qs_pkg::MODE_PP;
    wr(qs_pkg::OFS_QS_DECEL, 32'h1234);
    foreach (m[i]) begin
      wr(qs_pkg::OFS_QS_METHOD, 32'(m[i]));
      rdr(qs_pkg::OFS_QS_OPTION);
      ck("option", 32'(m[i]), rd);
      go_open();
      u_qs_ctrl_model.cmd(1'b0, 1'b0, 1'b0);
      tick(3);
      ck("brake", 32'(m[i] == 3'h0), 32'(db));
      ck("src", 32'(s[i]), 32'(src));
      ck("rate", (s[i] == 3'h2) ? 32'h1234 : 32'h0, rate);
      tick(14);
      ck("servo", 32'(m[i][2]), 32'(srv));
      ck("end", m[i][2] ? 32'h2 : 32'h0, 32'(pds));
      leave();
    end
  endtask
  task automatic t_brake();
    for (int i = 0; i < 4; i++) begin
      go_open();
      if (i == 0) wr(qs_pkg::OFS_CTRL, 32'h0);
      @(posedge clk);
      cs <= (i == 1);
      mode <= (i == 2) ? qs_pkg::MODE_TQ : (i == 3) ? qs_pkg::MODE_CT : qs_pkg::MODE_CSP;
      u_qs_ctrl_model.cmd(1'b0, 1'b0, 1'b0);
      tick(3);
      ck("db", 32'h1, 32'(db));
      ck("no decel", 32'h0, 32'(dec));
      tick(14);
      ck("db end", 32'h0, 32'(pds));
      wr(qs_pkg::OFS_CTRL, 32'h1);
      cs <= 1'b0;
      mode <= qs_pkg::MODE_CSP;
      u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b0);
    end
  endtask
  task automatic t_pin();
    go_open();
    em2 <= 1'b0;
    tick(5);
    ck("pin src", 32'h2, 32'(src));
    tick(14);
    ck("pin servo", 32'h0, 32'(srv));
    em2 <= 1'b1;
    tick(4);
  endtask
  task automatic t_slave();
    @(posedge clk);
    mode <= qs_pkg::MODE_SLT;
    go_open();
    u_qs_ctrl_model.cmd(1'b0, 1'b0, 1'b0);
    tick(3);
    ck("slave ignore", 32'h1, 32'(pds));
    ck("slave no decel", 32'h0, 32'(dec));
    ck("slave irq", 32'h1, 32'(irq));
    @(posedge clk);
    ms <= 1'b1;
    tick(2);
    ck("master src", 32'h4, 32'(src));
    ck("master pds", 32'h1, 32'(pds));
    tick(14);
    ck("master end", 32'h0, 32'(srv));
    ms <= 1'b0;
    u_qs_ctrl_model.cmd(1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_during();
    @(posedge clk);
    mode <= qs_pkg::MODE_PP;
    for (int j = 0; j < 3; j++) begin
      go_open();
      u_qs_ctrl_model.cmd(1'b0, 1'b0, 1'b0);
      tick(2);
      alm <= (j == 0);
      wq <= (j == 1);
      wf <= (j == 2);
      tick(3);
      ck("mid pds", (j == 0) ? 32'h3 : 32'h2, 32'(pds));
      ck("mid src", (j == 1) ? 32'h3 : 32'h2, 32'(src));
      tick(14);
      ck("mid servo", 32'h0, 32'(srv));
      if (j == 0) begin
        rdr(qs_pkg::OFS_IRQ_STS);
        ck("fault irq", 32'h3, 32'(rd[3:2]));
      end
      alm <= 1'b0;
      wq <= 1'b0;
      wf <= 1'b0;
      leave();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_irq();
    t_methods();
    t_brake();
    t_pin();
    t_slave();
    t_during();
    end_sim();
  end
endmodule
